/* core/blc_pkg.sv */
package blc_pkg;

	// ****************************************************************
	// Frame patterns and check sequence
	// ****************************************************************
	localparam logic [7:0] BLC_FLAG = 8'h7e;
	localparam logic [7:0] BLC_MARK_CHAR = 8'hff;
	localparam logic [15:0] BLC_CRC_INIT = 16'hffff;
	localparam logic [15:0] BLC_CRC_POLY_REFL = 16'h8408;
	localparam logic [15:0] BLC_CRC_RESIDUE = 16'hf0b8;
	localparam logic [2:0] BLC_STUFF_RUN = 3'h5;
	localparam logic [2:0] BLC_PEND_RUN = 3'h6;
	localparam logic [2:0] BLC_ABORT_RUN = 3'h7;
	localparam logic [4:0] BLC_CHAR_LAST = 5'h07;
	localparam logic [4:0] BLC_FCS_LAST = 5'h0f;
	localparam logic [2:0] BLC_CHAR_BIT_LAST = 3'h7;

	// ****************************************************************
	// Receive delay line: flag bits already pushed, then the check field
	// ****************************************************************
	localparam int BLC_FLAG_DEPTH = 6;
	localparam int BLC_PIPE_DEPTH = 22;
	localparam logic [4:0] BLC_FLAG_DEPTH_C = 5'h06;
	localparam logic [4:0] BLC_PIPE_DEPTH_C = 5'h16;

	// ****************************************************************
	// Bit clock recovery in the 32x mode
	// ****************************************************************
	localparam logic [4:0] BLC_PH_LAST = 5'h1f;
	localparam logic [4:0] BLC_PH_MID = 5'h0f;

	// ****************************************************************
	// Register addresses and field positions
	// ****************************************************************
	localparam logic [2:0] BLC_ADDR_CTL = 3'h0;
	localparam logic [2:0] BLC_ADDR_STAT = 3'h1;
	localparam logic [2:0] BLC_ADDR_CAUSE = 3'h2;
	localparam logic [2:0] BLC_ADDR_DATA = 3'h3;
	localparam logic [7:0] BLC_CTL_RESET = 8'h00;
	localparam int BLC_CTL_SPARE = 0;
	localparam int BLC_CTL_TX_EN = 1;
	localparam int BLC_CTL_RX_EN = 2;
	localparam int BLC_CTL_ONLINE = 3;
	localparam int BLC_CTL_SEND = 4;
	localparam int BLC_CTL_CLOSE = 5;
	localparam int BLC_CTL_ABORT = 6;
	localparam int BLC_IRQ_RX_END = 7;
	localparam int BLC_IRQ_RX_ERR = 6;
	localparam int BLC_IRQ_TX_END = 5;
	localparam int BLC_IRQ_UNDER = 4;
	localparam int BLC_IRQ_MODEM = 3;
	localparam int BLC_ST_CRC_OK = 0;
	localparam int BLC_ST_IN_FRAME = 1;
	localparam int BLC_ST_ABORTED = 2;
	localparam int BLC_ST_OVERRUN = 3;
	localparam int BLC_ST_SPARE = 4;
	localparam logic [1:0] BLC_EDGE_ASSERT = 2'h1;
	localparam logic [1:0] BLC_EDGE_RELEASE = 2'h2;
	localparam logic [1:0] BLC_EDGE_BOTH = 2'h3;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic cs_n;
		logic re_n;
		logic we_n;
		logic [2:0] addr;
		logic [7:0] data;
		logic close_n;
		logic tx_clk;
		logic rx_clk;
		logic rx_data;
		logic pll_1x;
		logic nrzi_n;
		logic spare;
		logic permit_n;
		logic online_n;
		logic bell_n;
		logic sense_n;
		logic [1:0] bell_sel;
		logic [1:0] sense_sel;
	} blc_pins_t;

	typedef enum logic [1:0] {TX_IDLE, TX_FLAG, TX_DATA, TX_FCS} blc_tx_state_t;

	// One bit of the reflected check: bit 0 holds the x^15 term.
	function automatic logic [15:0] blc_crc_step(input logic [15:0] crc, input logic bit_in);
		logic fb;
		fb = crc[0] ^ bit_in;
		blc_crc_step = {1'b0, crc[15:1]} ^ (fb ? BLC_CRC_POLY_REFL : 16'h0000);
	endfunction : blc_crc_step

endpackage : blc_pkg

/* core/blc_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
module blc_buf2
	import blc_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	typedef struct packed {
		logic [1:0][WIDTH-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} blc_buf_state_t;

	blc_buf_state_t q;
	blc_buf_state_t n;
	logic push;
	logic pop;

	assign in_ready = (q.cnt != 2'h2);
	assign out_valid = (q.cnt != 2'h0);
	assign out_data = q.mem[q.rp];

	always_comb
	begin
		n = q;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push)
		begin
			n.mem[q.wp] = in_data;
			n.wp = ~q.wp;
		end
		if (pop)
			n.rp = ~q.rp;
		n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			q <= '0;
		else
			q <= n;
	end

endmodule : blc_buf2
`default_nettype wire

/* core/blc_link_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module blc_link_ctrl
	import blc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic bus_cs_n,
	input wire logic bus_re_n,
	input wire logic bus_we_n,
	input wire logic [2:0] bus_addr,
	input wire logic [7:0] bus_d_in,
	output logic [7:0] bus_d_out,
	output logic bus_d_oe_n,
	input wire logic close_frame_in,
	output logic irq_out,
	output logic tx_hold_empty,
	output logic rx_hold_full,
	output logic line_tx_out,
	input wire logic tx_bit_clk,
	input wire logic rx_bit_clk,
	input wire logic line_rx_in,
	input wire logic pll_sel_in,
	input wire logic nrzi_sel_n,
	output logic spare_out,
	input wire logic spare_in,
	output logic host_online_out,
	output logic send_wish_out,
	input wire logic send_permit_in,
	input wire logic modem_online_in,
	input wire logic bell_signal_in,
	input wire logic line_sense_in,
	input wire logic [1:0] bell_irq_sel,
	input wire logic [1:0] sense_irq_sel
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		blc_pins_t s1;
		blc_pins_t s2;
		logic txc_l;
		logic rxc_l;
		logic rxd_l;
		logic bell_l;
		logic sense_l;
		logic rd_act;
		logic wr_act;
		logic [2:0] acc_addr;
		logic [7:0] wr_data;
		logic [7:0] rd;
		logic [7:0] ctl;
		logic [7:0] cause;
		logic [7:0] hold;
		logic hold_full;
		logic close_req;
		logic abort_req;
		blc_tx_state_t tx_st;
		logic [7:0] tx_sh;
		logic [4:0] tx_cnt;
		logic [2:0] tx_ones;
		logic [15:0] tx_crc;
		logic [4:0] tx_ph;
		logic line;
		logic [4:0] rx_ph;
		logic rx_prev;
		logic [2:0] rx_ones;
		logic [BLC_PIPE_DEPTH-1:0] pipe;
		logic [4:0] pcnt;
		logic [15:0] rx_crc;
		logic [7:0] rx_ch;
		logic [2:0] rx_ccnt;
		logic in_frame;
		logic crc_ok;
		logic aborted;
		logic overrun;
	} blc_state_t;

	blc_state_t q;
	blc_state_t n;
	blc_pins_t pin_in;
	logic rd_on, wr_on, rd_end, wr_end, nrzi, tx_go;
	logic txc_rise, txc_fall, rxc_rise, tx_tick, rx_tick;
	logic stuff, bit_o, last, rawb, dbit, push, cbit;
	logic buf_push, buf_ready, buf_valid, buf_pop;
	logic [7:0] buf_in, buf_out, status;

	// Modem inputs are active low; the selector picks which change interrupts.
	function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
		edge_hit = ((sel == BLC_EDGE_ASSERT || sel == BLC_EDGE_BOTH) && prev && !cur) ||
			((sel == BLC_EDGE_RELEASE || sel == BLC_EDGE_BOTH) && !prev && cur);
	endfunction : edge_hit

	assign pin_in = {bus_cs_n, bus_re_n, bus_we_n, bus_addr, bus_d_in, close_frame_in, tx_bit_clk,
		rx_bit_clk, line_rx_in, pll_sel_in, nrzi_sel_n, spare_in, send_permit_in, modem_online_in,
		bell_signal_in, line_sense_in, bell_irq_sel, sense_irq_sel};

	// ****************************************************************
	// Receive character buffer
	// ****************************************************************
	blc_buf2 #(
		.WIDTH(8)
	) u_rx_buf (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.in_valid(buf_push),
		.in_ready(buf_ready),
		.in_data(buf_in),
		.out_valid(buf_valid),
		.out_ready(buf_pop),
		.out_data(buf_out)
	);

	always_comb
	begin
		n = q;
		n.s1 = pin_in;
		n.s2 = q.s1;
		n.txc_l = q.s2.tx_clk;
		n.rxc_l = q.s2.rx_clk;
		n.rxd_l = q.s2.rx_data;
		n.bell_l = q.s2.bell_n;
		n.sense_l = q.s2.sense_n;
		nrzi = !q.s2.nrzi_n;
		tx_go = q.ctl[BLC_CTL_TX_EN] && !q.s2.permit_n;
		status = {q.s2.sense_n, q.s2.online_n, q.s2.permit_n, q.s2.spare, q.overrun, q.aborted,
			q.in_frame, q.crc_ok};
		stuff = 1'b0;
		bit_o = 1'b1;
		last = 1'b0;
		rawb = q.s2.rx_data;
		dbit = 1'b0;
		push = 1'b0;
		cbit = q.pipe[BLC_PIPE_DEPTH-1];
		buf_push = 1'b0;
		buf_in = {cbit, q.rx_ch[7:1]};

		// ****************************************************************
		// Bit timing from the sampled link clocks
		// ****************************************************************
		txc_rise = !q.txc_l && q.s2.tx_clk;
		txc_fall = q.txc_l && !q.s2.tx_clk;
		rxc_rise = !q.rxc_l && q.s2.rx_clk;
		if (q.s2.pll_1x)
		begin
			tx_tick = txc_fall;
			rx_tick = rxc_rise;
		end
		else
		begin
			tx_tick = txc_rise && (q.tx_ph == BLC_PH_LAST);
			rx_tick = rxc_rise && (q.rx_ph == BLC_PH_MID);
			if (txc_rise)
				n.tx_ph = q.tx_ph + 5'h01;
			if (q.s2.rx_data != q.rxd_l)
				n.rx_ph = '0;
			else if (rxc_rise)
				n.rx_ph = q.rx_ph + 5'h01;
		end

		// ****************************************************************
		// Host strobes
		// ****************************************************************
		rd_on = !q.s2.cs_n && !q.s2.re_n;
		wr_on = !q.s2.cs_n && !q.s2.we_n;
		rd_end = q.rd_act && !rd_on;
		wr_end = q.wr_act && !wr_on;
		buf_pop = rd_end && (q.acc_addr == BLC_ADDR_DATA);
		n.rd_act = rd_on;
		n.wr_act = wr_on;
		if (rd_on || wr_on)
			n.acc_addr = q.s2.addr;
		if (wr_on)
			n.wr_data = ~q.s2.data;
		if (rd_on)
		begin
			case (q.s2.addr)
				BLC_ADDR_CTL: n.rd = q.ctl;
				BLC_ADDR_STAT: n.rd = status;
				BLC_ADDR_CAUSE: n.rd = q.cause;
				BLC_ADDR_DATA: n.rd = buf_out;
				default: n.rd = 8'h00;
			endcase
		end
		if (rd_end && q.acc_addr == BLC_ADDR_CAUSE)
			n.cause = q.cause & ~q.rd;
		if (!q.s2.close_n)
			n.close_req = 1'b1;

		// ****************************************************************
		// Transmitter
		// ****************************************************************
		if (tx_tick)
		begin
			stuff = (q.tx_st == TX_DATA || q.tx_st == TX_FCS || (q.tx_st == TX_FLAG && q.tx_cnt == 5'h00)) &&
				q.tx_ones == BLC_STUFF_RUN;
			bit_o = stuff ? 1'b0 : ((q.tx_st == TX_FCS) ? ~q.tx_crc[0] : q.tx_sh[0]);
			n.line = nrzi ? (bit_o ? q.line : ~q.line) : bit_o;
			if (stuff)
				n.tx_ones = '0;
			else
			begin
				if (q.tx_st == TX_DATA || q.tx_st == TX_FCS)
					n.tx_ones = bit_o ? q.tx_ones + 3'h1 : 3'h0;
				n.tx_sh = {1'b1, q.tx_sh[7:1]};
				if (q.tx_st == TX_DATA)
					n.tx_crc = blc_crc_step(q.tx_crc, bit_o);
				else if (q.tx_st == TX_FCS)
					n.tx_crc = {1'b0, q.tx_crc[15:1]};
				last = q.tx_cnt == ((q.tx_st == TX_FCS) ? BLC_FCS_LAST : BLC_CHAR_LAST);
				n.tx_cnt = last ? 5'h00 : q.tx_cnt + 5'h01;
			end
			if (last)
			begin
				case (q.tx_st)
					TX_IDLE:
					begin
						n.tx_st = tx_go ? TX_FLAG : TX_IDLE;
						n.tx_sh = tx_go ? BLC_FLAG : BLC_MARK_CHAR;
					end
					TX_FLAG:
					begin
						n.close_req = 1'b0;
						if (q.abort_req)
						begin
							n.abort_req = 1'b0;
							n.tx_sh = BLC_MARK_CHAR;
						end
						else if (q.hold_full && tx_go)
						begin
							n.tx_st = TX_DATA;
							n.tx_sh = q.hold;
							n.hold_full = 1'b0;
							n.tx_crc = BLC_CRC_INIT;
							n.tx_ones = '0;
						end
						else
						begin
							n.tx_st = tx_go ? TX_FLAG : TX_IDLE;
							n.tx_sh = tx_go ? BLC_FLAG : BLC_MARK_CHAR;
						end
					end
					TX_DATA:
					begin
						if (q.abort_req)
						begin
							n.abort_req = 1'b0;
							n.tx_st = TX_FLAG;
							n.tx_sh = BLC_MARK_CHAR;
						end
						else if (q.hold_full)
						begin
							n.tx_sh = q.hold;
							n.hold_full = 1'b0;
						end
						else if (q.close_req)
						begin
							n.close_req = 1'b0;
							n.tx_st = TX_FCS;
						end
						else
						begin
							n.cause[BLC_IRQ_UNDER] = 1'b1;
							n.tx_st = TX_FLAG;
							n.tx_sh = BLC_MARK_CHAR;
						end
					end
					TX_FCS:
					begin
						n.tx_st = TX_FLAG;
						n.tx_sh = BLC_FLAG;
						n.cause[BLC_IRQ_TX_END] = 1'b1;
					end
					default: n.tx_st = TX_IDLE;
				endcase
			end
		end

		// ****************************************************************
		// Receiver
		// ****************************************************************
		if (rx_tick)
		begin
			dbit = nrzi ? (rawb == q.rx_prev) : rawb;
			n.rx_prev = rawb;
			if (dbit)
			begin
				n.rx_ones = (q.rx_ones == BLC_ABORT_RUN) ? BLC_ABORT_RUN : q.rx_ones + 3'h1;
				push = q.rx_ones < BLC_STUFF_RUN;
				if (q.rx_ones == BLC_PEND_RUN)
				begin
					if (q.in_frame)
					begin
						n.cause[BLC_IRQ_RX_ERR] = 1'b1;
						n.aborted = 1'b1;
					end
					n.in_frame = 1'b0;
				end
			end
			else
			begin
				n.rx_ones = '0;
				push = q.rx_ones != BLC_STUFF_RUN && q.rx_ones != BLC_PEND_RUN;
				if (q.rx_ones == BLC_PEND_RUN)
				begin
					if (q.in_frame && q.pcnt == BLC_PIPE_DEPTH_C)
					begin
						n.crc_ok = q.rx_crc == BLC_CRC_RESIDUE;
						n.aborted = 1'b0;
						n.cause[BLC_IRQ_RX_END] = 1'b1;
						if (q.rx_crc != BLC_CRC_RESIDUE)
							n.cause[BLC_IRQ_RX_ERR] = 1'b1;
					end
					n.in_frame = q.ctl[BLC_CTL_RX_EN];
					n.rx_crc = BLC_CRC_INIT;
					n.pcnt = '0;
					n.rx_ccnt = '0;
				end
			end
			if (push)
			begin
				n.pipe = {q.pipe[BLC_PIPE_DEPTH-2:0], dbit};
				if (q.pcnt != BLC_PIPE_DEPTH_C)
					n.pcnt = q.pcnt + 5'h01;
				if (q.pcnt >= BLC_FLAG_DEPTH_C)
					n.rx_crc = blc_crc_step(q.rx_crc, q.pipe[BLC_FLAG_DEPTH-1]);
				if (q.pcnt == BLC_PIPE_DEPTH_C)
				begin
					n.rx_ch = buf_in;
					n.rx_ccnt = q.rx_ccnt + 3'h1;
					if (q.rx_ccnt == BLC_CHAR_BIT_LAST && q.in_frame)
					begin
						buf_push = 1'b1;
						if (!buf_ready)
						begin
							n.overrun = 1'b1;
							n.cause[BLC_IRQ_RX_ERR] = 1'b1;
						end
					end
				end
			end
		end

		// ****************************************************************
		// Modem change events and register writes
		// ****************************************************************
		if (edge_hit(q.s2.bell_sel, q.bell_l, q.s2.bell_n) ||
			edge_hit(q.s2.sense_sel, q.sense_l, q.s2.sense_n))
			n.cause[BLC_IRQ_MODEM] = 1'b1;
		if (wr_end)
		begin
			case (q.acc_addr)
				BLC_ADDR_CTL:
				begin
					n.ctl = q.wr_data & ~8'h60;
					if (q.wr_data[BLC_CTL_CLOSE])
						n.close_req = 1'b1;
					if (q.wr_data[BLC_CTL_ABORT])
						n.abort_req = 1'b1;
					if (!q.wr_data[BLC_CTL_RX_EN])
						n.in_frame = 1'b0;
				end
				BLC_ADDR_STAT: n.overrun = buf_push && !buf_ready;
				BLC_ADDR_DATA:
				begin
					n.hold = q.wr_data;
					n.hold_full = 1'b1;
				end
				default: n.hold_full = n.hold_full;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			q <= '0;
			q.s1 <= '1;
			q.s2 <= '1;
			q.txc_l <= 1'b1;
			q.rxc_l <= 1'b1;
			q.bell_l <= 1'b1;
			q.sense_l <= 1'b1;
			q.ctl <= BLC_CTL_RESET;
			q.tx_sh <= BLC_MARK_CHAR;
			q.line <= 1'b1;
		end
		else
			q <= n;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign bus_d_out = ~q.rd;
	assign bus_d_oe_n = ~q.rd_act;
	assign irq_out = |q.cause[7:3];
	assign tx_hold_empty = ~q.hold_full;
	assign rx_hold_full = buf_valid;
	assign line_tx_out = q.line;
	assign spare_out = q.ctl[BLC_CTL_SPARE];
	assign host_online_out = ~q.ctl[BLC_CTL_ONLINE];
	assign send_wish_out = ~q.ctl[BLC_CTL_SEND];

endmodule : blc_link_ctrl
`default_nettype wire

/* tb/blc_link_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module blc_link_ctrl_chk
	import blc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic bus_cs_n,
	input wire logic bus_re_n,
	input wire logic bus_we_n,
	input wire logic [2:0] bus_addr,
	input wire logic bus_d_oe_n,
	input wire logic irq_out,
	input wire logic tx_hold_empty,
	input wire logic rx_hold_full,
	input wire logic line_tx_out,
	input wire logic tx_bit_clk,
	input wire logic pll_sel_in,
	input wire logic spare_out,
	input wire logic host_online_out,
	input wire logic send_wish_out
);
	// ****************************************************************
	// Cycles since the last strobe of each kind and since the last bit clock fall
	// ****************************************************************
	logic [3:0] age_q [4];
	logic [3:0] fall_q;
	logic tclk_q;
	logic [3:0] hit;
	assign hit = {4{~bus_cs_n}} & {~bus_re_n & (bus_addr == BLC_ADDR_DATA), ~bus_re_n & (bus_addr == BLC_ADDR_CAUSE),
		~bus_we_n & (bus_addr == BLC_ADDR_DATA), ~bus_we_n & (bus_addr == BLC_ADDR_CTL)};
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			age_q <= '{default: 4'hf};
			fall_q <= 4'hf;
			tclk_q <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < 4; i++)
				age_q[i] <= hit[i] ? 4'h0 : age_q[i] + {3'h0, age_q[i] != 4'hf};
			fall_q <= (tclk_q && !tx_bit_clk) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hf};
			tclk_q <= tx_bit_clk;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_rd_held;
		(!bus_cs_n && !bus_re_n) [*4];
	endsequence
	sequence s_idle_held;
		bus_cs_n [*4];
	endsequence
	sequence s_no_read;
		bus_re_n [*4];
	endsequence
	AST_OE_READ: assert property (s_rd_held |-> !bus_d_oe_n)
		else $error("data bus not driven during a held read");
	AST_OE_IDLE: assert property (s_idle_held |-> bus_d_oe_n)
		else $error("data bus driven while not selected");
	AST_OE_WRITE: assert property (s_no_read |-> bus_d_oe_n)
		else $error("data bus driven without a read strobe");
	AST_RESET_IDLE: assert property (disable iff (1'b0) !rstn |-> bus_d_oe_n && !irq_out && tx_hold_empty
		&& !rx_hold_full && line_tx_out && !spare_out && host_online_out && send_wish_out)
		else $error("outputs not idle in reset");
	AST_TX_EDGE: assert property ($changed(line_tx_out) && pll_sel_in |-> fall_q <= 4'h8)
		else $error("serial output changed away from a bit clock fall");
	AST_TXE_WRITE: assert property ($fell(tx_hold_empty) |-> age_q[1] <= 4'h8)
		else $error("transmit hold filled without a data write");
	AST_RXF_READ: assert property ($fell(rx_hold_full) |-> age_q[3] <= 4'h8)
		else $error("receive hold emptied without a data read");
	AST_IRQ_READ: assert property ($fell(irq_out) |-> age_q[2] <= 4'h8)
		else $error("interrupt dropped without a cause read");
	AST_SPARE_WRITE: assert property ($changed(spare_out) |-> age_q[0] <= 4'h8)
		else $error("spare output changed without a control write");
	AST_MODEM_WRITE: assert property ($changed({host_online_out, send_wish_out}) |-> age_q[0] <= 4'h8)
		else $error("modem outputs changed without a control write");
endmodule : blc_link_ctrl_chk
bind blc_link_ctrl blc_link_ctrl_chk i_blc_link_ctrl_chk (.clk_sys, .rstn, .bus_cs_n, .bus_re_n, .bus_we_n,
	.bus_addr, .bus_d_oe_n, .irq_out, .tx_hold_empty, .rx_hold_full, .line_tx_out, .tx_bit_clk, .pll_sel_in,
	.spare_out, .host_online_out, .send_wish_out);
`default_nettype wire

/* tb/blc_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module blc_line_model
	import blc_pkg::*;
(
	output logic tx_bit_clk,
	output logic rx_bit_clk,
	output logic line_rx_in,
	input wire logic line_tx_out,
	input wire logic nrzi_n
);
	// ****************************************************************
	// Line equipment: free transmit clock, receive clock only within frames
	// ****************************************************************
	logic [7:0] sh;
	logic prev;
	logic [15:0] res_q [$];
	logic [7:0] byte_q [$];
	logic raw [$];
	function automatic logic [15:0] step(input logic [15:0] c, input logic b);
		return {1'b0, c[15:1]} ^ ((c[0] ^ b) ? 16'h8408 : 16'h0000);
	endfunction : step
	initial
	begin
		rx_bit_clk = 1'b0;
		line_rx_in = 1'b1;
		prev = 1'b1;
		sh = 8'hff;
		tx_bit_clk = 1'b0;
		#13;
		forever #80 tx_bit_clk = ~tx_bit_clk;
	end
	always @(posedge tx_bit_clk)
	begin : cap
		logic b;
		logic [15:0] c;
		logic [7:0] v;
		int ones;
		logic d [$];
		b = nrzi_n ? line_tx_out : (line_tx_out == prev);
		prev = line_tx_out;
		sh = {b, sh[7:1]};
		raw.push_back(b);
		if (sh == 8'hff)
			raw = {};
		if (sh == BLC_FLAG)
		begin
			repeat (8) void'(raw.pop_back());
			d = {};
			ones = 0;
			c = 16'hffff;
			foreach (raw[i])
			begin
				if (ones != 5 || raw[i])
				begin
					d.push_back(raw[i]);
					c = step(c, raw[i]);
				end
				ones = raw[i] ? ones + 1 : 0;
			end
			raw = {};
			if (d.size() >= 32)
			begin
				res_q.push_back(c);
				for (int i = 0; i + 24 <= d.size(); i += 8)
				begin
					for (int k = 0; k < 8; k++)
						v[k] = d[i + k];
					byte_q.push_back(v);
				end
			end
		end
	end
	task automatic put(input logic b);
		line_rx_in = nrzi_n ? b : (b ? line_rx_in : ~line_rx_in);
		#80 rx_bit_clk = 1'b1;
		#80 rx_bit_clk = 1'b0;
	endtask : put
	task automatic send(input logic [7:0] q [$], input logic bad);
		logic s [$];
		logic [15:0] c;
		int ones;
		c = 16'hffff;
		ones = 0;
		foreach (q[i])
			for (int k = 0; k < 8; k++)
			begin
				s.push_back(q[i][k]);
				c = step(c, q[i][k]);
			end
		c = ~c ^ {15'h0000, bad};
		for (int k = 0; k < 16; k++)
			s.push_back(c[k]);
		for (int k = 0; k < 8; k++)
			put(BLC_FLAG[k]);
		foreach (s[i])
		begin
			put(s[i]);
			ones = s[i] ? ones + 1 : 0;
			if (ones == 5)
			begin
				put(1'b0);
				ones = 0;
			end
		end
		for (int k = 0; k < 16; k++)
			put(BLC_FLAG[k % 8]);
	endtask : send
endmodule : blc_line_model
`default_nettype wire

/* tb/blc_link_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module blc_link_ctrl_tb
	import blc_pkg::*;
;
	logic clk_sys, rstn, bus_cs_n, bus_re_n, bus_we_n, close_frame_in, pll_sel_in, nrzi_sel_n, spare_in;
	logic send_permit_in, modem_online_in, bell_signal_in, line_sense_in, line_rx_in, tx_bit_clk, rx_bit_clk;
	logic bus_d_oe_n, irq_out, tx_hold_empty, rx_hold_full, line_tx_out, spare_out, host_online_out, send_wish_out;
	logic [2:0] bus_addr;
	logic [7:0] bus_d_in, bus_d_out;
	logic [1:0] bell_irq_sel, sense_irq_sel;
	int errors, num_checks, cyc;
	blc_link_ctrl i_blc_link_ctrl (.clk_sys, .rstn, .bus_cs_n, .bus_re_n, .bus_we_n, .bus_addr, .bus_d_in, .bus_d_out,
		.bus_d_oe_n, .close_frame_in, .irq_out, .tx_hold_empty, .rx_hold_full, .line_tx_out, .tx_bit_clk, .rx_bit_clk,
		.line_rx_in, .pll_sel_in, .nrzi_sel_n, .spare_out, .spare_in, .host_online_out, .send_wish_out, .send_permit_in,
		.modem_online_in, .bell_signal_in, .line_sense_in, .bell_irq_sel, .sense_irq_sel);
	blc_line_model i_blc_line_model (.tx_bit_clk, .rx_bit_clk, .line_rx_in, .line_tx_out, .nrzi_n(nrzi_sel_n));
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			errors++;
			test_done();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	// Strobes are held four cycles and released five more, as the synchronisers need.
	task automatic bus_acc(input logic [2:0] a, input logic wr, input logic [7:0] wv, output logic [7:0] rv);
		@(posedge clk_sys);
		#1 bus_cs_n = 1'b0;
		bus_addr = a;
		bus_d_in = ~wv;
		bus_we_n = !wr;
		bus_re_n = wr;
		repeat (4) @(posedge clk_sys);
		rv = ~bus_d_out;
		#1 {bus_cs_n, bus_re_n, bus_we_n} = 3'h7;
		repeat (5) @(posedge clk_sys);
	endtask : bus_acc
	initial
	begin : main
		logic [7:0] v;
		logic [7:0] q [$];
		int n;
		{bus_cs_n, bus_re_n, bus_we_n, close_frame_in, pll_sel_in, nrzi_sel_n} = 6'h3f;
		{modem_online_in, bell_signal_in, line_sense_in, send_permit_in, spare_in, rstn} = 6'h39;
		{bus_addr, bus_d_in, bell_irq_sel, sense_irq_sel} = 15'h00ff << 4;
		void'($urandom(32'h3e0f));
		#1 rstn = 1'b0;
		repeat (10) @(posedge clk_sys);
		chk({bus_d_oe_n, irq_out, tx_hold_empty, rx_hold_full, line_tx_out, spare_out, host_online_out, send_wish_out},
			8'hab);
		#1 rstn = 1'b1;
		spare_in = 1'($urandom);
		bus_acc(BLC_ADDR_CTL, 1'b0, 8'h00, v);
		chk(v, BLC_CTL_RESET);
		bus_acc(BLC_ADDR_CTL, 1'b1, 8'h19, v);
		chk({spare_out, host_online_out, send_wish_out}, 3'h4);
		bus_acc(BLC_ADDR_CTL, 1'b0, 8'h00, v);
		chk(v, 8'h19);
		bus_acc(BLC_ADDR_STAT, 1'b0, 8'h00, v);
		chk(v[4], spare_in);
		bus_acc(3'h7, 1'b0, 8'h00, v);
		chk(v, 8'h00);
		$display("register test done");
		for (int m = 0; m < 3; m++)
		begin
			#1 nrzi_sel_n = (m != 1);
			q = {};
			n = 3 + $urandom % 3;
			repeat (n) q.push_back($urandom);
			q[1] = 8'hff;
			bus_acc(BLC_ADDR_CTL, 1'b1, 8'h1e, v);
			foreach (q[i])
			begin
				while (!tx_hold_empty) @(posedge clk_sys);
				bus_acc(BLC_ADDR_DATA, 1'b1, q[i], v);
			end
			while (!tx_hold_empty) @(posedge clk_sys);
			if (m == 0)
				#1 close_frame_in = 1'b0;
			else
				bus_acc(BLC_ADDR_CTL, 1'b1, 8'h3e, v);
			while (i_blc_line_model.res_q.size() == 0) @(posedge clk_sys);
			#1 close_frame_in = 1'b1;
			chk(i_blc_line_model.res_q.pop_front(), BLC_CRC_RESIDUE);
			chk(i_blc_line_model.byte_q.size(), n);
			foreach (q[i])
				chk(i_blc_line_model.byte_q.pop_front(), q[i]);
			i_blc_line_model.byte_q = {};
			chk(irq_out, 1'b1);
			bus_acc(BLC_ADDR_CAUSE, 1'b0, 8'h00, v);
			chk(v & 8'h20, 8'h20);
			chk(irq_out, 1'b0);
			bus_acc(BLC_ADDR_CTL, 1'b1, 8'h04, v);
			fork
				i_blc_line_model.send(q, m == 1);
				if (m != 2)
					foreach (q[i])
					begin
						while (!rx_hold_full) @(posedge clk_sys);
						bus_acc(BLC_ADDR_DATA, 1'b0, 8'h00, v);
						chk(v, q[i]);
					end
			join
			repeat (20) @(posedge clk_sys);
			for (int i = 0; i < 2 && m == 2; i++)
			begin
				bus_acc(BLC_ADDR_DATA, 1'b0, 8'h00, v);
				chk(v, q[i]);
			end
			chk(rx_hold_full, 1'b0);
			bus_acc(BLC_ADDR_STAT, 1'b0, 8'h00, v);
			chk(v[0] | (m == 2), m != 1);
			chk(irq_out, 1'b1);
			bus_acc(BLC_ADDR_CAUSE, 1'b0, 8'h00, v);
			chk(v[7:6] & {m == 0, 1'b1}, {m == 0, m != 0});
			$display("frame test %0d done", m);
		end
		#1 bell_irq_sel = BLC_EDGE_ASSERT;
		sense_irq_sel = BLC_EDGE_RELEASE;
		repeat (4) @(posedge clk_sys);
		for (int k = 0; k < 2; k++)
		begin
			#1 {bell_signal_in, line_sense_in} = {2{k[0]}};
			repeat (10) @(posedge clk_sys);
			chk(irq_out, 1'b1);
			bus_acc(BLC_ADDR_CAUSE, 1'b0, 8'h00, v);
			chk(v, 8'h08);
			bus_acc(BLC_ADDR_STAT, 1'b0, 8'h00, v);
			chk(v[7:5], {line_sense_in, modem_online_in, send_permit_in});
		end
		$display("modem test done");
		#1 pll_sel_in = 1'b0;
		bus_acc(BLC_ADDR_CTL, 1'b1, 8'h12, v);
		while (line_tx_out) @(posedge clk_sys);
		n = 0;
		while (!line_tx_out)
		begin
			n++;
			@(posedge clk_sys);
		end
		chk(n, 32 * 40);
		$display("clock mode test done");
		test_done();
	end
endmodule : blc_link_ctrl_tb
`default_nettype wire
